// File: rwpc_cpu_model.sv
// cpu and interrupt controller stand-in: sleeps on request, hands over a wake mask
// assumes the core_clk of rwpc_top, sleep_go pulsed for one cycle by the bench
`timescale 1ns/100ps
module rwpc_cpu_model (
  input  wire logic        core_clk,      // system clock
  input  wire logic        chip_rst,      // internal reset
  input  wire logic        cpu_wake,      // wake pulse
  input  wire logic        sleep_go,      // bench asks for sleep
  input  wire logic [31:0] go_mask,       // enabled, urgent irqs
  output logic             cpu_sleep,     // sleep request level
  output logic [31:0]      nic_wake_mask  // mask to the wake unit
);
  logic held_r;
  initial begin
    cpu_sleep = 1'b0;
    nic_wake_mask = 32'h0;
    held_r = 1'b0;
  end
  // mask only good at the take edge, inverted after so a late sample shows
  always @(posedge core_clk) begin
    held_r <= 1'b0;
    if (chip_rst || cpu_wake) begin
      cpu_sleep <= 1'b0;
    end else if (sleep_go && !cpu_sleep) begin
      cpu_sleep <= 1'b1;
      nic_wake_mask <= go_mask;
      held_r <= 1'b1;
    end
    if (held_r) begin
      nic_wake_mask <= ~nic_wake_mask;
    end
  end
endmodule

// File: rwpc_map.svh
// register offsets, field positions, reset values and counts
// assumes inclusion from rwpc_pkg and the bench
`ifndef RWPC_MAP_SVH
`define RWPC_MAP_SVH
`define RWPC_A_CTRL      8'h00
`define RWPC_A_STAT      8'h04
`define RWPC_A_MASK      8'h08
`define RWPC_A_LIVE      8'h0C
`define RWPC_A_PPWR      8'h10
`define RWPC_A_EFLG      8'h14
`define RWPC_A_EEN       8'h18
`define RWPC_CTRL_OSC    0
`define RWPC_CTRL_EWAKE  1
`define RWPC_ST_BOD      0
`define RWPC_ST_WAKE     1
`define RWPC_ST_DPDX     2
`define RWPC_ST_EINT     3
`define RWPC_ST_W        4
`define RWPC_EINT_N      31
`define RWPC_IRQ_N       32
`define RWPC_WAKE_CLKS   256
`define RWPC_BOOT_ADDR   32'h00000000
`define RWPC_PPWR_RST    32'hFFFFFFFF
`endif

// File: rwpc_pkg.sv
// types of the reset, wake and power control block
// assumes rwpc_map.svh on the include path
package rwpc_pkg;
  `include "rwpc_map.svh"

  typedef enum logic [2:0] {
    PM_RUN   = 3'b001,
    PM_SLEEP = 3'b010,
    PM_DPD   = 3'b100
  } rwpc_pm_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rwpc_bus_t;

  typedef struct packed {
    rwpc_pm_t                 pm;
    logic                     chip_rst;
    logic [15:0]              wcnt;
    logic [31:0]              boot_addr;
    logic                     cpu_clk_en;
    logic                     cpu_wake;
    logic                     core_pwr;
    logic                     osc_pwr;
    logic [31:0]              ppwr;
    logic [31:0]              ppwr_o;
    logic                     irq;
    logic                     bod_irq;
    logic [`RWPC_EINT_N-1:0]  eflg;
    logic [`RWPC_EINT_N-1:0]  een;
    logic [`RWPC_EINT_N-1:0]  eprev;
    logic [1:0]               ctrl;
    logic [`RWPC_ST_W-1:0]    stat;
    logic [`RWPC_ST_W-1:0]    mask;
    logic [`RWPC_IRQ_N-1:0]   wmask;
    logic                     sleep_d;
    logic [31:0]              rdata;
  } rwpc_state_t;

  localparam rwpc_state_t RWPC_ST_RST = '{
    pm: PM_RUN, chip_rst: 1'b1, boot_addr: `RWPC_BOOT_ADDR,
    cpu_clk_en: 1'b1, core_pwr: 1'b1, osc_pwr: 1'b1,
    ppwr: `RWPC_PPWR_RST, ppwr_o: `RWPC_PPWR_RST, default: '0};
endpackage

// File: rwpc_tb.sv
// self-checking bench: reset merge, brownout, sleep, deep power-down, ext ints
// assumes rwpc_pkg compiled first and rwpc_cpu_model beside it
`timescale 1ns/100ps
`include "rwpc_map.svh"
module tb;
  import rwpc_pkg::*;
  localparam logic [15:0] WCLK = 16'h0008;
  logic core_clk, srst, osc_ok, flash_done, bod_low, rtc_dpd_req, rtc_alarm, sleep_go, rd_seen;
  logic chip_rst, cpu_clk_en, cpu_wake, core_pwr_en, osc32k_pwr_en, bod_irq, irq, cpu_sleep;
  logic wdt_rst, por_rst, bod_crit, rst_pin_n;
  logic [3:0] srcs;
  logic [30:0] eint_in, eint_flag;
  logic [31:0] irq_lines, nic_wake_mask, go_mask, reg_rdata, boot_addr, periph_pwr_en, pat;
  rwpc_bus_t bus_req;
  logic [31:0] expq[$];
  int fail_count, tests_run, i, k, b;

  assign {rst_pin_n, bod_crit, por_rst, wdt_rst} = {~srcs[3], srcs[2:0]};

  rwpc_top #(.WAKE_CLKS(WCLK)) dut_u (
    .core_clk, .srst, .rst_pin_n, .wdt_rst, .por_rst, .bod_low, .bod_crit, .osc_ok, .flash_done,
    .rtc_dpd_req, .rtc_alarm, .cpu_sleep, .nic_wake_mask, .irq_lines, .eint_in, .bus_req,
    .reg_rdata, .chip_rst, .boot_addr, .cpu_clk_en, .cpu_wake, .core_pwr_en, .osc32k_pwr_en,
    .periph_pwr_en, .eint_flag, .bod_irq, .irq);
  rwpc_cpu_model cpu_u (.core_clk, .chip_rst, .cpu_wake, .sleep_go, .go_mask, .cpu_sleep,
    .nic_wake_mask);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic neg(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one-cycle strobe; a read notes its expected word for the watcher
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) expq.push_back(d);
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic wait_rel();
    k = 0;
    while (chip_rst !== 1'b0 && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    check(chip_rst, 1'b0);
    check(boot_addr, 32'h0);
  endtask
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge core_clk) rd_seen <= bus_req.rd;
  always @(negedge core_clk) begin
    if (rd_seen) check(reg_rdata, expq.pop_front());
    else if (!srst) check(reg_rdata, 32'h0);
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    k = $urandom(32'h52e5);
    {srst, osc_ok, flash_done, bod_low, rtc_dpd_req, rtc_alarm, sleep_go, rd_seen} = 8'h80;
    {srcs, eint_in, irq_lines, go_mask, bus_req} = '0;
    fail_count = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    bus(`RWPC_A_CTRL, 32'h0, 0);
    bus(`RWPC_A_PPWR, 32'hFFFFFFFF, 0);
    bus(`RWPC_A_EEN, 32'h0, 0);
    bus(8'h1C, 32'h0, 0);
    neg(1);
    check(chip_rst, 1'b1);
    @(posedge core_clk);
    osc_ok <= 1'b1;
    neg(int'(WCLK) + 3);
    check(chip_rst, 1'b1);
    @(posedge core_clk);
    flash_done <= 1'b1;
    wait_rel();
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      srcs <= 4'h1 << i;
      #1 check(chip_rst, 1'b1);
      @(posedge core_clk);
      srcs <= (i == 2) ? 4'h2 : 4'h0;
      neg(2);
      check(chip_rst, 1'b1);
      @(posedge core_clk);
      srcs <= 4'h0;
      wait_rel();
    end
    @(posedge core_clk);
    bod_low <= 1'b1;
    neg(2);
    check(bod_irq, 1'b1);
    bus(`RWPC_A_STAT, 32'h1, 0);
    bus(`RWPC_A_LIVE, 32'h11, 0);
    bus(`RWPC_A_MASK, 32'h1, 1);
    neg(2);
    check(irq, 1'b1);
    @(posedge core_clk);
    bod_low <= 1'b0;
    bus(`RWPC_A_STAT, 32'h1, 1);
    neg(2);
    check({irq, bod_irq}, 2'b00);
    pat = $urandom;
    bus(`RWPC_A_PPWR, pat, 1);
    neg(1);
    check(periph_pwr_en, pat);
    b = $urandom_range(31, 0);
    @(posedge core_clk);
    go_mask <= 32'h1 << b;
    sleep_go <= 1'b1;
    @(posedge core_clk);
    sleep_go <= 1'b0;
    irq_lines <= ~(32'h1 << b);
    neg(4);
    check(cpu_clk_en, 1'b0);
    @(posedge core_clk);
    irq_lines <= 32'h1 << b;
    neg(1);
    check(cpu_wake, 1'b0);
    neg(1);
    check({cpu_wake, cpu_clk_en}, 2'b11);
    neg(1);
    check(cpu_wake, 1'b0);
    @(posedge core_clk);
    irq_lines <= '0;
    bus(`RWPC_A_STAT, 32'h2, 0);
    bus(`RWPC_A_EEN, 32'h7FFFFFFF, 1);
    bus(`RWPC_A_CTRL, 32'h2, 1);
    for (i = 0; i < 3; i++) begin
      b = $urandom_range(29, 0);
      @(posedge core_clk);
      eint_in <= 31'h1 << b;
      neg(3);
      check(eint_flag, 31'h1 << b);
      bus(`RWPC_A_EFLG, 32'h1 << b, 0);
      bus(`RWPC_A_EFLG, 32'h1 << b, 1);
      neg(2);
      check(eint_flag, 31'h0);
      @(posedge core_clk);
      eint_in <= '0;
    end
    @(posedge core_clk);
    go_mask <= 32'h0;
    sleep_go <= 1'b1;
    @(posedge core_clk);
    sleep_go <= 1'b0;
    neg(3);
    check(cpu_clk_en, 1'b0);
    @(posedge core_clk);
    eint_in <= 31'h40000000;
    neg(4);
    check({cpu_clk_en, eint_flag[30]}, 2'b11);
    @(posedge core_clk);
    eint_in <= '0;
    neg(3);
    check(eint_flag, 31'h0);
    bus(`RWPC_A_STAT, 32'hF, 1);
    for (i = 0; i < 2; i++) begin
      bus(`RWPC_A_CTRL, 32'(i), 1);
      @(posedge core_clk);
      rtc_dpd_req <= 1'b1;
      @(posedge core_clk);
      rtc_dpd_req <= 1'b0;
      irq_lines <= '1;
      neg(3);
      check({core_pwr_en, cpu_clk_en, osc32k_pwr_en}, {2'b00, i[0]});
      check(periph_pwr_en, 32'h0);
      bus(`RWPC_A_LIVE, 32'h40, 0);
      @(posedge core_clk);
      irq_lines <= '0;
      if (i == 0) rtc_alarm <= 1'b1;
      else srcs <= 4'h8;
      @(posedge core_clk);
      rtc_alarm <= 1'b0;
      srcs <= 4'h0;
      neg(1);
      check({core_pwr_en, chip_rst}, 2'b11);
      check(periph_pwr_en, (i != 0) ? 32'hFFFFFFFF : pat);
      wait_rel();
      bus(`RWPC_A_STAT, (i != 0) ? 32'h0 : 32'h4, 0);
      bus(`RWPC_A_STAT, 32'hF, 1);
    end
    neg(2);
    complete_run();
  end
endmodule

// File: rwpc_top.sv
// reset merge, wake-up timer, brownout, deep power-down, wake-up interrupt unit
// assumes cpu and nested_interrupt_ctrl on the far side, all inputs but the async reset sources on core_clk
`timescale 1ns/100ps
module rwpc_top #(
  parameter logic [15:0] WAKE_CLKS = 16'(`RWPC_WAKE_CLKS)
) (
  input  wire logic                           core_clk,        // 125 MHz system clock
  input  wire logic                           srst,            // sync reset, active high
  input  wire logic                           rst_pin_n,       // external reset pin, low active
  input  wire logic                           wdt_rst,         // watchdog reset request
  input  wire logic                           por_rst,         // power-on reset source
  input  wire logic                           bod_low,         // supply below first threshold
  input  wire logic                           bod_crit,        // supply below second threshold
  input  wire logic                           osc_ok,          // oscillator running
  input  wire logic                           flash_done,      // flash controller ready
  input  wire logic                           rtc_dpd_req,     // deep power-down request
  input  wire logic                           rtc_alarm,       // rtc alarm match
  input  wire logic                           cpu_sleep,       // cpu entering sleep
  input  wire logic [`RWPC_IRQ_N-1:0]         nic_wake_mask,   // mask from interrupt ctrl
  input  wire logic [`RWPC_IRQ_N-1:0]         irq_lines,       // raw interrupt lines
  input  wire logic [`RWPC_EINT_N-1:0]        eint_in,         // external interrupt pins
  input  rwpc_pkg::rwpc_bus_t                 bus_req,         // register port request
  output logic [31:0]                         reg_rdata,       // read data, next cycle
  output logic                                chip_rst,        // internal reset
  output logic [31:0]                         boot_addr,       // first fetch address
  output logic                                cpu_clk_en,      // cpu clock gate
  output logic                                cpu_wake,        // wake pulse
  output logic                                core_pwr_en,     // core domain power
  output logic                                osc32k_pwr_en,   // 32 kHz oscillator power
  output logic [31:0]                         periph_pwr_en,   // per-peripheral power
  output logic [`RWPC_EINT_N-1:0]             eint_flag,       // external interrupt requests
  output logic                                bod_irq,         // brownout interrupt request
  output logic                                irq              // block interrupt
);
  import rwpc_pkg::*;

  rwpc_state_t              st_r;
  rwpc_state_t              st_nxt;
  logic [1:0]               rsync_r;
  logic                     rst_any;
  logic [`RWPC_EINT_N-1:0]  eflg_nxt;
  logic [`RWPC_EINT_N-1:0]  eclr;
  logic                     wr_eflg;
  logic                     wake_hit;

  // brownout and power-on share one path; either alone holds reset
  assign rst_any = !rst_pin_n || wdt_rst || por_rst || bod_crit;

  // release of the async source is retimed before the timer may start
  always_ff @(posedge core_clk or posedge rst_any) begin
    if (rst_any) begin
      rsync_r <= 2'b11;
    end else begin
      rsync_r <= {rsync_r[0], 1'b0};
    end
  end

  assign wr_eflg = bus_req.wr && (bus_req.addr == `RWPC_A_EFLG);
  assign eclr    = wr_eflg ? bus_req.wdata[`RWPC_EINT_N-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `RWPC_EINT_N; gi++) begin : g_eint
      if (gi == `RWPC_EINT_N-1) begin : g_lvl
        // level input: flag follows the pin, nothing to clear
        assign eflg_nxt[gi] = eint_in[gi] && st_r.een[gi];
      end else begin : g_edge
        // a new edge wins over a clear in the same cycle
        assign eflg_nxt[gi] = (st_r.eflg[gi] && !eclr[gi]) ||
                              (st_r.een[gi] && eint_in[gi] && !st_r.eprev[gi]);
      end
    end
  endgenerate

  assign wake_hit = |(irq_lines & st_r.wmask) ||
                    (st_r.ctrl[`RWPC_CTRL_EWAKE] && |st_r.eflg);

  always_comb begin
    logic [`RWPC_ST_W-1:0] sset;
    logic [`RWPC_ST_W-1:0] sclr;
    sset = '0;
    sclr = '0;
    st_nxt = st_r;
    st_nxt.cpu_wake = 1'b0;
    st_nxt.rdata = '0;
    st_nxt.eprev = eint_in;
    st_nxt.eflg = eflg_nxt;
    st_nxt.sleep_d = cpu_sleep;
    st_nxt.bod_irq = bod_low;
    sset[`RWPC_ST_BOD] = bod_low;
    sset[`RWPC_ST_EINT] = |eflg_nxt;

    // wake-up timer; count stalls while the oscillator is down
    // the count saturates at the limit, so a late flash ready simply
    // extends the hold, while a late pin release restarts the count; release
    // needs every condition in the same cycle, which keeps the
    // exit a single clean edge on chip_rst
    if (rsync_r[1]) begin
      st_nxt.chip_rst = 1'b1;
      st_nxt.wcnt = '0;
    end else if (st_r.chip_rst) begin
      if (osc_ok && st_r.wcnt != WAKE_CLKS) begin
        st_nxt.wcnt = st_r.wcnt + 16'd1;
      end
      if (rst_pin_n && osc_ok && flash_done && st_r.wcnt == WAKE_CLKS) begin
        st_nxt.chip_rst = 1'b0;
      end
    end

    // power mode machine; deep power-down is checked before sleep
    // so a request from the clock unit wins over a sleeping cpu
    // in the same cycle; nothing is accepted while in reset
    case (st_r.pm)
      PM_RUN: begin
        if (rtc_dpd_req && !st_r.chip_rst) begin
          st_nxt.pm = PM_DPD;
          st_nxt.core_pwr = 1'b0;
          st_nxt.cpu_clk_en = 1'b0;
        end else if (cpu_sleep && !st_r.sleep_d && !st_r.chip_rst) begin
          st_nxt.pm = PM_SLEEP;
          st_nxt.wmask = nic_wake_mask;
          st_nxt.cpu_clk_en = 1'b0;
        end
      end
      PM_SLEEP: begin
        if (wake_hit) begin
          st_nxt.pm = PM_RUN;
          st_nxt.cpu_clk_en = 1'b1;
          st_nxt.cpu_wake = 1'b1;
          sset[`RWPC_ST_WAKE] = 1'b1;
        end
      end
      PM_DPD: begin
        // only the alarm leaves here; the pin goes through the reset path
        if (rtc_alarm) begin
          st_nxt.pm = PM_RUN;
          st_nxt.core_pwr = 1'b1;
          st_nxt.cpu_clk_en = 1'b1;
          st_nxt.chip_rst = 1'b1;
          st_nxt.wcnt = '0;
          sset[`RWPC_ST_DPDX] = 1'b1;
        end
      end
      default: begin
        st_nxt.pm = PM_RUN;
      end
    endcase

    // register writes; unmapped offsets and the live view are
    // ignored, and writes still land in deep power-down since the
    // register file is modelled as always powered
    if (bus_req.wr) begin
      if (bus_req.addr == `RWPC_A_CTRL) begin
        st_nxt.ctrl = bus_req.wdata[1:0];
      end else if (bus_req.addr == `RWPC_A_STAT) begin
        sclr = bus_req.wdata[`RWPC_ST_W-1:0];
      end else if (bus_req.addr == `RWPC_A_MASK) begin
        st_nxt.mask = bus_req.wdata[`RWPC_ST_W-1:0];
      end else if (bus_req.addr == `RWPC_A_PPWR) begin
        st_nxt.ppwr = bus_req.wdata;
      end else if (bus_req.addr == `RWPC_A_EEN) begin
        st_nxt.een = bus_req.wdata[`RWPC_EINT_N-1:0];
      end
    end
    st_nxt.stat = (st_r.stat & ~sclr) | sset;  // set beats clear

    if (bus_req.rd) begin
      if (bus_req.addr == `RWPC_A_CTRL) begin
        st_nxt.rdata = {30'h0, st_r.ctrl};
      end else if (bus_req.addr == `RWPC_A_STAT) begin
        st_nxt.rdata = {28'h0, st_r.stat};
      end else if (bus_req.addr == `RWPC_A_MASK) begin
        st_nxt.rdata = {28'h0, st_r.mask};
      end else if (bus_req.addr == `RWPC_A_LIVE) begin
        // bit 3 stays zero so the mode field sits at bits 6:4
        st_nxt.rdata = {25'h0, st_r.pm, 1'b0, st_r.chip_rst, bod_crit, bod_low};
      end else if (bus_req.addr == `RWPC_A_PPWR) begin
        st_nxt.rdata = st_r.ppwr;
      end else if (bus_req.addr == `RWPC_A_EFLG) begin
        st_nxt.rdata = {1'b0, st_r.eflg};
      end else if (bus_req.addr == `RWPC_A_EEN) begin
        st_nxt.rdata = {1'b0, st_r.een};
      end
    end

    // outputs follow next state so power and gating change together
    st_nxt.ppwr_o = (st_nxt.pm == PM_DPD) ? '0 : st_nxt.ppwr;
    st_nxt.osc_pwr = (st_nxt.pm == PM_DPD) ? st_nxt.ctrl[`RWPC_CTRL_OSC] : 1'b1;
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    st_nxt.boot_addr = `RWPC_BOOT_ADDR;

    if (srst) begin
      st_nxt = RWPC_ST_RST;
    end
  end

  // every register takes its reset value on any source
  always_ff @(posedge core_clk or posedge rst_any) begin
    if (rst_any) begin
      st_r <= RWPC_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata     = st_r.rdata;
  assign chip_rst      = st_r.chip_rst;
  assign boot_addr     = st_r.boot_addr;
  assign cpu_clk_en    = st_r.cpu_clk_en;
  assign cpu_wake      = st_r.cpu_wake;
  assign core_pwr_en   = st_r.core_pwr;
  assign osc32k_pwr_en = st_r.osc_pwr;
  assign periph_pwr_en = st_r.ppwr_o;
  assign eint_flag     = st_r.eflg;
  assign bod_irq       = st_r.bod_irq;
  assign irq           = st_r.irq;

  // checks below run on the system clock and stay quiet in srst or while a source is active;
  // the two reset checks name their own disable so that they still
  // watch the cycles in which a source is active
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst || rst_any);

  chk_src_reset: assert property (@(posedge core_clk) disable iff (srst)
    (wdt_rst || !rst_pin_n) |=> st_r.chip_rst)
    else $error("reset source did not hold chip reset");
  chk_bod_reset: assert property (@(posedge core_clk) disable iff (srst)
    (bod_crit || por_rst) |=> st_r.chip_rst ##1 (st_r.wcnt == 16'h0000))
    else $error("brownout or por did not restart reset");
  chk_rst_hold: assert property (st_r.chip_rst && !flash_done |=> st_r.chip_rst)
    else $error("reset released before flash ready");
  chk_rst_count: assert property ($fell(st_r.chip_rst) |-> $past(st_r.wcnt) == WAKE_CLKS)
    else $error("reset released before wake count");
  chk_rel_sync: assert property ($fell(st_r.chip_rst) |-> $past(osc_ok) && $past(flash_done))
    else $error("reset released with conditions unmet");
  chk_boot_addr: assert property ($fell(st_r.chip_rst) |-> boot_addr == 32'h00000000)
    else $error("boot address not zero at release");
  chk_bod_flag: assert property (bod_low && !(bus_req.wr && bus_req.addr == `RWPC_A_STAT)
    |=> st_r.stat[`RWPC_ST_BOD] && bod_irq)
    else $error("brownout warning not flagged");
  chk_dpd_entry: assert property ($rose(st_r.pm == PM_DPD) |-> $past(rtc_dpd_req) && !core_pwr_en
    && periph_pwr_en == 32'h00000000)
    else $error("deep power-down entered wrongly");
  chk_osc_opt: assert property (st_r.pm == PM_DPD |-> osc32k_pwr_en == st_r.ctrl[`RWPC_CTRL_OSC])
    else $error("oscillator power option ignored");
  chk_dpd_exit: assert property (st_r.pm == PM_DPD && !rtc_alarm && !srst |=> st_r.pm == PM_DPD)
    else $error("deep power-down left without alarm");
  chk_wic_wake: assert property (st_r.pm == PM_SLEEP && |(irq_lines & st_r.wmask)
    |=> cpu_wake && cpu_clk_en ##1 !cpu_wake)
    else $error("masked interrupt did not wake cpu");
  chk_eint_wake: assert property (st_r.pm == PM_SLEEP && st_r.ctrl[`RWPC_CTRL_EWAKE]
    && |st_r.eflg |=> st_r.pm == PM_RUN)
    else $error("external interrupt did not wake");
  chk_eint_level: assert property (eint_flag[`RWPC_EINT_N-1] |->
    $past(eint_in[`RWPC_EINT_N-1]) && $past(st_r.een[`RWPC_EINT_N-1]))
    else $error("level interrupt flag without level");
  chk_periph_off: assert property (bus_req.wr && bus_req.addr == `RWPC_A_PPWR
    && st_r.pm == PM_RUN && !rtc_dpd_req |=> periph_pwr_en == $past(bus_req.wdata))
    else $error("peripheral power write not applied");

  // read data is zero except in the cycle after a read strobe
  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");

  chk_irq_level: assert property (irq == |(st_r.stat & st_r.mask))
    else $error("interrupt level disagrees with status");

  // sleep entry captures the mask offered in the entry cycle
  chk_sleep_entry: assert property (st_r.pm == PM_RUN && cpu_sleep && !st_r.sleep_d
    && !st_r.chip_rst && !rtc_dpd_req
    |=> st_r.pm == PM_SLEEP && st_r.wmask == $past(nic_wake_mask) && !cpu_clk_en)
    else $error("sleep entry or mask capture wrong");

  // no wake without a masked line or, with EWAKE set, an external flag: the unit never polls the cpu awake
  chk_no_poll: assert property (st_r.pm == PM_SLEEP && !wake_hit
    |=> !cpu_wake && !cpu_clk_en)
    else $error("cpu woken without a masked interrupt");

  chk_wake_flag: assert property (cpu_wake |-> st_r.stat[`RWPC_ST_WAKE])
    else $error("wake not recorded in status");

  chk_dpd_power: assert property (st_r.pm == PM_DPD
    |-> !core_pwr_en && !cpu_clk_en && periph_pwr_en == 32'h00000000)
    else $error("power left on in deep power-down");

  chk_alarm_exit: assert property (st_r.pm == PM_DPD && rtc_alarm
    |=> st_r.pm == PM_RUN && core_pwr_en && chip_rst)
    else $error("alarm did not leave deep power-down");

  chk_osc_run: assert property (st_r.pm != PM_DPD |-> osc32k_pwr_en)
    else $error("oscillator off outside deep power-down");

  chk_run_power: assert property (st_r.pm != PM_DPD |-> periph_pwr_en == st_r.ppwr)
    else $error("peripheral power differs from register");

  // any enabled rising edge on the edge inputs must leave a flag
  chk_edge_flag: assert property (|(st_r.een[`RWPC_EINT_N-2:0] & eint_in[`RWPC_EINT_N-2:0]
    & ~st_r.eprev[`RWPC_EINT_N-2:0]) |=> |eint_flag[`RWPC_EINT_N-2:0])
    else $error("edge interrupt flag not set");
endmodule
